// File: hw/arc_params.svh
// constants of the accumulator calculation unit
`ifndef ARC_PARAMS_SVH
`define ARC_PARAMS_SVH

// command opcode and register map
`define ARC_CALC_OPCODE 16'h00A5
`define ARC_ACC_IDX 8'h0A
`define ARC_TARGET_IDX 8'h14
`define ARC_POSITION_IDX 8'h15

// condition flag positions
`define ARC_FLAG_ZERO 0
`define ARC_FLAG_POS 1
`define ARC_FLAG_NEG 2

// operation codes
`define ARC_OP_CLEAR 5'h00
`define ARC_OP_ADD 5'h01
`define ARC_OP_SUB 5'h02
`define ARC_OP_LOAD 5'h03
`define ARC_OP_INC 5'h04
`define ARC_OP_DEC 5'h05
`define ARC_OP_ABS 5'h06
`define ARC_OP_SUB_POS 5'h07
`define ARC_OP_STORE 5'h08
`define ARC_OP_LOAD_HI 5'h09
`define ARC_OP_LOAD_LO 5'h0A
`define ARC_OP_AND 5'h0B
`define ARC_OP_OR 5'h0C
`define ARC_OP_XOR 5'h0D
`define ARC_OP_DIV 5'h0E
`define ARC_OP_MUL_U 5'h0F
`define ARC_OP_MUL_S 5'h10
`define ARC_OP_ACC_HI 5'h11
`define ARC_OP_LOAD_IND 5'h12
`define ARC_OP_STORE_IND 5'h13
`define ARC_OP_PUT_HI 5'h14
`define ARC_OP_PUT_LO 5'h15
`define ARC_OP_SHL 5'h16
`define ARC_OP_ASR 5'h17
`define ARC_OP_LSR 5'h18
`define ARC_OP_MOD 5'h19
`define ARC_OP_MAX 5'h1A
`define ARC_OP_MIN 5'h1B
`define ARC_OP_RSUB 5'h1C
`define ARC_OP_NEG 5'h1D
`define ARC_OP_ADD_HI 5'h1E
`define ARC_OP_ADD_LO 5'h1F

// divider step count
`define ARC_DIV_STEPS 6'h20

`endif

// File: hw/arc_pkg.sv
// types of the accumulator calculation unit
package arc_pkg;
    typedef enum logic [1:0] {ARC_ST_IDLE, ARC_ST_LOAD, ARC_ST_DIV, ARC_ST_CALC} arc_state_t;
    typedef logic [31:0] arc_word_t;
endpackage

// File: hw/arc_divider.sv
// unsigned 32 by 16 bit restoring divider
`timescale 1ns/1ps
`default_nettype none
`include "arc_params.svh"

module arc_divider (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic [31:0] dividend,
    input wire logic [15:0] divisor,
    output logic done,
    output logic [31:0] quotient,
    output logic [15:0] remainder
);
    logic [5:0] count;
    logic [16:0] trial;
    logic fits;

    // one quotient bit per cycle
    assign trial = {remainder, quotient[31]};
    assign fits = trial >= {1'b0, divisor};

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            count <= 6'h00;
            quotient <= 32'h0000_0000;
            remainder <= 16'h0000;
            done <= 1'b0;
        end else begin
            done <= count == 6'h01;
            if (start) begin
                count <= `ARC_DIV_STEPS;
                quotient <= dividend;
                remainder <= 16'h0000;
            end else if (count != 6'h00) begin
                count <= count - 6'h01;
                quotient <= {quotient[30:0], fits};
                remainder <= fits ? 16'(trial - {1'b0, divisor}) : trial[15:0];
            end
        end
    end
endmodule
`default_nettype wire

// File: hw/arc_calc_unit.sv
// accumulator based register calculation unit
`timescale 1ns/1ps
`default_nettype none
`include "arc_params.svh"

module arc_calc_unit #(
    parameter int REG_COUNT = 256
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [15:0] cmd_opcode,
    input wire logic [15:0] cmd_param,
    input wire logic cmd_thread2,
    output logic done,
    output logic [31:0] result,
    output logic [2:0] flags_t1,
    output logic [2:0] flags_t2,
    input wire logic load_en,
    input wire logic load_thread2,
    input wire logic [7:0] load_idx,
    input wire logic [31:0] load_data,
    input wire logic [7:0] rd_idx,
    input wire logic rd_thread2,
    output logic [31:0] rd_data
);
    // ------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------
    logic [31:0] regs [REG_COUNT];
    arc_pkg::arc_word_t acc_t2;
    arc_pkg::arc_state_t state;
    logic [4:0] op_q;
    logic op_ok;
    logic thr_q;
    logic [7:0] sel_q;
    logic [7:0] ptr_q;
    arc_pkg::arc_word_t op_a, op_b, op_ind, op_t, op_p;

    // read a register as seen by one thread
    function automatic logic [31:0] read_reg(input logic [7:0] idx, input logic thr);
        read_reg = (idx == `ARC_ACC_IDX && thr) ? acc_t2 : regs[idx];
    endfunction

    // sign-extend a half word
    function automatic logic [31:0] sext16(input logic [15:0] h);
        sext16 = {{16{h[15]}}, h};
    endfunction

    // zero, positive, negative of a result
    function automatic logic [2:0] flags_of(input logic [31:0] v);
        logic [2:0] f;
        f = 3'h0;
        f[`ARC_FLAG_ZERO] = v == 32'h0000_0000;
        f[`ARC_FLAG_POS] = !v[31] && v != 32'h0000_0000;
        f[`ARC_FLAG_NEG] = v[31];
        flags_of = f;
    endfunction

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic accept;
    logic [7:0] live_sel;
    logic [31:0] live_acc, live_b, live_mag;
    logic live_div;

    assign accept = cmd_valid && cmd_ready;
    assign live_sel = cmd_param[7:0];
    // accumulator is register 10 of the issuing thread
    assign live_acc = thr_q ? acc_t2 : regs[`ARC_ACC_IDX];
    assign live_b = (sel_q == `ARC_ACC_IDX && thr_q) ? acc_t2 : regs[sel_q];
    assign live_mag = live_acc[31] ? 32'h0000_0000 - live_acc : live_acc;
    assign live_div = op_ok && (op_q == `ARC_OP_DIV || op_q == `ARC_OP_MOD);

    // ------------------------------------------------------------
    // divider
    // ------------------------------------------------------------
    logic div_done;
    logic [31:0] div_q;
    logic [15:0] div_r;
    logic [31:0] quo_signed, mod_pos;

    arc_divider u_div (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .start(state == arc_pkg::ARC_ST_LOAD && live_div),
        .dividend(live_mag),
        .divisor(live_b[15:0]),
        .done(div_done),
        .quotient(div_q),
        .remainder(div_r)
    );

    assign quo_signed = op_a[31] ? 32'h0000_0000 - div_q : div_q;
    // negative dividend folds remainder up into range
    assign mod_pos = (op_a[31] && div_r != 16'h0000) ?
        {16'h0000, op_b[15:0] - div_r} : {16'h0000, div_r};

    // ------------------------------------------------------------
    // arithmetic
    // ------------------------------------------------------------
    logic [31:0] mul_u, mul_s;
    logic a_gt_b;

    assign mul_u = op_a * op_b;
    assign mul_s = 32'($signed(op_a) * $signed(op_b));
    assign a_gt_b = $signed(op_a) > $signed(op_b);

    logic [31:0] next_val, next_pos;
    logic wr_acc, wr_sel, wr_ptr, wr_pos;

    // operation select
    always_comb begin
        next_val = op_a;
        next_pos = op_p;
        wr_acc = 1'b0;
        wr_sel = 1'b0;
        wr_ptr = 1'b0;
        wr_pos = 1'b0;
        if (op_ok) begin
            case (op_q)
                `ARC_OP_CLEAR: begin next_val = 32'h0000_0000; wr_sel = 1'b1; end
                `ARC_OP_ADD: begin next_val = op_a + op_b; wr_acc = 1'b1; end
                `ARC_OP_SUB: begin next_val = op_a - op_b; wr_acc = 1'b1; end
                `ARC_OP_RSUB: begin next_val = op_b - op_a; wr_acc = 1'b1; end
                `ARC_OP_LOAD: begin next_val = op_b; wr_acc = 1'b1; end
                `ARC_OP_STORE: begin next_val = op_a; wr_sel = 1'b1; end
                `ARC_OP_INC: begin next_val = op_b + 32'h0000_0001; wr_sel = 1'b1; end
                `ARC_OP_DEC: begin next_val = op_b - 32'h0000_0001; wr_sel = 1'b1; end
                `ARC_OP_ABS: begin
                    next_val = op_b[31] ? 32'h0000_0000 - op_b : op_b;
                    wr_sel = 1'b1;
                end
                `ARC_OP_NEG: begin next_val = 32'h0000_0000 - op_b; wr_sel = 1'b1; end
                `ARC_OP_SUB_POS: begin
                    next_val = op_t - op_b;
                    next_pos = op_p - op_b;
                    wr_pos = 1'b1;
                end
                `ARC_OP_LOAD_HI: begin next_val = sext16(op_b[31:16]); wr_acc = 1'b1; end
                `ARC_OP_LOAD_LO: begin next_val = sext16(op_b[15:0]); wr_acc = 1'b1; end
                `ARC_OP_AND: begin next_val = op_a & op_b; wr_acc = 1'b1; end
                `ARC_OP_OR: begin next_val = op_a | op_b; wr_acc = 1'b1; end
                `ARC_OP_XOR: begin next_val = op_a ^ op_b; wr_acc = 1'b1; end
                `ARC_OP_DIV: begin next_val = quo_signed; wr_acc = 1'b1; end
                `ARC_OP_MOD: begin next_val = mod_pos; wr_acc = 1'b1; end
                `ARC_OP_MUL_U: begin next_val = mul_u; wr_acc = 1'b1; end
                `ARC_OP_MUL_S: begin next_val = mul_s; wr_acc = 1'b1; end
                `ARC_OP_ACC_HI: begin next_val = {op_b[15:0], op_a[15:0]}; wr_acc = 1'b1; end
                `ARC_OP_LOAD_IND: begin next_val = op_ind; wr_acc = 1'b1; end
                `ARC_OP_STORE_IND: begin next_val = op_a; wr_ptr = 1'b1; end
                `ARC_OP_PUT_HI: begin next_val = {op_a[15:0], op_b[15:0]}; wr_sel = 1'b1; end
                `ARC_OP_PUT_LO: begin next_val = {op_b[31:16], op_a[15:0]}; wr_sel = 1'b1; end
                `ARC_OP_SHL: begin next_val = {op_b[30:0], 1'b0}; wr_sel = 1'b1; end
                `ARC_OP_ASR: begin next_val = {op_b[31], op_b[31:1]}; wr_sel = 1'b1; end
                `ARC_OP_LSR: begin next_val = {1'b0, op_b[31:1]}; wr_sel = 1'b1; end
                `ARC_OP_MAX: begin next_val = a_gt_b ? op_a : op_b; wr_acc = 1'b1; end
                `ARC_OP_MIN: begin next_val = a_gt_b ? op_b : op_a; wr_acc = 1'b1; end
                `ARC_OP_ADD_HI: begin next_val = op_a + sext16(op_b[31:16]); wr_acc = 1'b1; end
                `ARC_OP_ADD_LO: begin next_val = op_a + sext16(op_b[15:0]); wr_acc = 1'b1; end
                default: begin next_val = op_a; end
            endcase
        end
    end

    // ------------------------------------------------------------
    // write back
    // ------------------------------------------------------------
    logic calc_cycle, wr_go, wr_is_t2acc;
    logic [7:0] wr_idx;

    assign calc_cycle = state == arc_pkg::ARC_ST_CALC;
    assign wr_go = calc_cycle && (wr_acc || wr_sel || wr_ptr || wr_pos);
    assign wr_idx = wr_acc ? `ARC_ACC_IDX : wr_ptr ? ptr_q : wr_pos ? `ARC_TARGET_IDX : sel_q;
    assign wr_is_t2acc = wr_idx == `ARC_ACC_IDX && thr_q;

    // shared register array
    always_ff @(posedge sys_clk) begin
        if (wr_go && !wr_is_t2acc) begin
            regs[wr_idx] <= next_val;
        end
        if (calc_cycle && wr_pos) begin
            regs[`ARC_POSITION_IDX] <= next_pos;
        end
        if (load_en && cmd_ready && !(load_idx == `ARC_ACC_IDX && load_thread2)) begin
            regs[load_idx] <= load_data;
        end
    end

    // second thread accumulator
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            acc_t2 <= 32'h0000_0000;
        end else if (wr_go && wr_is_t2acc) begin
            acc_t2 <= next_val;
        end else if (load_en && cmd_ready && load_idx == `ARC_ACC_IDX && load_thread2) begin
            acc_t2 <= load_data;
        end
    end

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    arc_pkg::arc_state_t next_state;

    always_comb begin
        next_state = state;
        case (state)
            arc_pkg::ARC_ST_IDLE: if (accept) next_state = arc_pkg::ARC_ST_LOAD;
            arc_pkg::ARC_ST_LOAD: next_state = live_div ? arc_pkg::ARC_ST_DIV : arc_pkg::ARC_ST_CALC;
            arc_pkg::ARC_ST_DIV: if (div_done) next_state = arc_pkg::ARC_ST_CALC;
            arc_pkg::ARC_ST_CALC: next_state = arc_pkg::ARC_ST_IDLE;
            default: next_state = arc_pkg::ARC_ST_IDLE;
        endcase
    end

    // state, ready and command latch
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= arc_pkg::ARC_ST_IDLE;
            cmd_ready <= 1'b1;
            op_q <= 5'h00;
            op_ok <= 1'b0;
            thr_q <= 1'b0;
            sel_q <= 8'h00;
        end else begin
            state <= next_state;
            cmd_ready <= next_state == arc_pkg::ARC_ST_IDLE;
            if (accept) begin
                op_q <= cmd_param[12:8];
                op_ok <= cmd_opcode == `ARC_CALC_OPCODE && cmd_param[15:13] == 3'h0;
                thr_q <= cmd_thread2;
                sel_q <= live_sel;
            end
        end
    end

    // operands captured one cycle after acceptance
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            op_a <= 32'h0000_0000;
            op_b <= 32'h0000_0000;
            op_ind <= 32'h0000_0000;
            op_t <= 32'h0000_0000;
            op_p <= 32'h0000_0000;
            ptr_q <= 8'h00;
        end else if (state == arc_pkg::ARC_ST_LOAD) begin
            op_a <= live_acc;
            op_b <= live_b;
            op_ind <= read_reg(live_b[7:0], thr_q);
            op_t <= read_reg(`ARC_TARGET_IDX, thr_q);
            op_p <= read_reg(`ARC_POSITION_IDX, thr_q);
            ptr_q <= live_b[7:0];
        end
    end

    // answer and per-thread condition flags
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            done <= 1'b0;
            result <= 32'h0000_0000;
            flags_t1 <= 3'h0;
            flags_t2 <= 3'h0;
            rd_data <= 32'h0000_0000;
        end else begin
            done <= calc_cycle;
            rd_data <= read_reg(rd_idx, rd_thread2);
            if (wr_go) begin
                result <= next_val;
                if (thr_q) flags_t2 <= flags_of(next_val);
                else flags_t1 <= flags_of(next_val);
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    AST_CLEAR: assert property (done && op_ok && op_q == `ARC_OP_CLEAR |-> result == 32'h0000_0000)
        else $error("clear did not give zero");
    AST_ADD: assert property (done && op_ok && op_q == `ARC_OP_ADD |-> result == op_a + op_b)
        else $error("add result wrong");
    AST_RSUB: assert property (done && op_ok && op_q == `ARC_OP_RSUB |-> result == op_b - op_a)
        else $error("reverse subtract wrong");
    AST_LOAD_LO: assert property (done && op_ok && op_q == `ARC_OP_LOAD_LO |-> result == sext16(op_b[15:0]))
        else $error("low half load wrong");
    AST_AND: assert property (done && op_ok && op_q == `ARC_OP_AND |-> result == (op_a & op_b))
        else $error("and result wrong");
    AST_MULU: assert property (done && op_ok && op_q == `ARC_OP_MUL_U |-> result == op_a * op_b)
        else $error("unsigned product wrong");
    AST_ACC_HI: assert property (done && op_ok && op_q == `ARC_OP_ACC_HI |-> result == {op_b[15:0], op_a[15:0]})
        else $error("high half replace wrong");
    AST_ASR: assert property (done && op_ok && op_q == `ARC_OP_ASR |-> result == {op_b[31], op_b[31:1]})
        else $error("arithmetic shift wrong");
    AST_MOD: assert property (done && op_ok && op_q == `ARC_OP_MOD && op_b[15:0] != 16'h0000 |-> !result[31] && result < {16'h0000, op_b[15:0]})
        else $error("remainder out of range");
    AST_MAX: assert property (done && op_ok && op_q == `ARC_OP_MAX |-> !($signed(result) < $signed(op_a)) && !($signed(result) < $signed(op_b)))
        else $error("max below an operand");
    AST_LATENCY: assert property (accept && !(cmd_param[12:8] == `ARC_OP_DIV || cmd_param[12:8] == `ARC_OP_MOD) |-> ##3 done)
        else $error("answer not three cycles after accept");
    AST_DIV_BOUND: assert property (accept |-> ##[3:40] done)
        else $error("divide answer too late");
    AST_T2_APART: assert property (calc_cycle && !thr_q |=> $stable(acc_t2) && $stable(flags_t2))
        else $error("thread one disturbed thread two");
    AST_FLAGS: assert property (done && op_ok && !thr_q && op_q != `ARC_OP_SUB_POS |-> flags_t1 == flags_of(result))
        else $error("flags do not follow result");
    AST_NOP: assert property (calc_cycle && !op_ok |=> $stable(flags_t1) && $stable(flags_t2) && $stable(result))
        else $error("ignored code changed state");

    COV_ADD: cover property (done && op_ok && op_q == `ARC_OP_ADD);
    COV_DIV: cover property (done && op_ok && op_q == `ARC_OP_DIV && op_a[31]);
    COV_T2: cover property (done && thr_q && op_ok);
    COV_NOP: cover property (done && !op_ok);
endmodule
`default_nettype wire

// File: tb/arc_seq_model.sv
// command sequencer model for the calculation unit
`timescale 1ns/1ps
`default_nettype none

module arc_seq_model (
    input wire logic sys_clk,
    input wire logic cmd_ready,
    input wire logic done,
    output logic cmd_valid,
    output logic [15:0] cmd_opcode,
    output logic [15:0] cmd_param,
    output logic cmd_thread2
);
    // idle levels before the first command
    initial begin
        cmd_valid = 1'b0;
        cmd_opcode = 16'h5A5A;
        cmd_param = 16'hA5A5;
        cmd_thread2 = 1'b0;
    end

    // offer, hold until taken, count edges up to done
    task automatic issue(input logic [15:0] opw, input logic [7:0] code,
        input logic [7:0] sel, input logic thr, input int gap, output logic [31:0] lat);
        int n;
        n = 0;
        lat = 32'hFFFF_FFFF;
        repeat (gap) @(posedge sys_clk);
        cmd_opcode <= opw;
        cmd_param <= {code, sel};
        cmd_thread2 <= thr;
        cmd_valid <= 1'b1;
        @(posedge sys_clk);
        while (cmd_ready !== 1'b1 && n < 50) begin
            n++;
            @(posedge sys_clk);
        end
        // released words show the inverse of the last value
        cmd_valid <= 1'b0;
        cmd_opcode <= ~opw;
        cmd_param <= ~{code, sel};
        for (n = 1; n <= 45; n++) begin
            @(posedge sys_clk);
            if (done === 1'b1) begin
                lat = 32'(n);
                break;
            end
        end
    endtask
endmodule
`default_nettype wire

// File: tb/tb_arc_calc_unit.sv
// self-checking bench for the accumulator calculation unit
`timescale 1ns/1ps
`default_nettype none

module tb_arc_calc_unit;
    logic sys_clk, resetn, cmd_valid, cmd_ready, cmd_thread2, done;
    logic load_en, load_thread2, rd_thread2;
    logic [15:0] cmd_opcode, cmd_param;
    logic [31:0] result, load_data, rd_data;
    logic [2:0] flags_t1, flags_t2;
    logic [7:0] load_idx, rd_idx;
    int failures = 0;
    int num_checks = 0;
    // codes whose result lands in the selected register
    localparam logic [31:0] REG_OPS = 32'h21F0_0171;

    arc_calc_unit #(.REG_COUNT(256)) u_arc_calc_unit (.sys_clk(sys_clk), .resetn(resetn),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode),
        .cmd_param(cmd_param), .cmd_thread2(cmd_thread2), .done(done), .result(result),
        .flags_t1(flags_t1), .flags_t2(flags_t2), .load_en(load_en),
        .load_thread2(load_thread2), .load_idx(load_idx), .load_data(load_data),
        .rd_idx(rd_idx), .rd_thread2(rd_thread2), .rd_data(rd_data));
    arc_seq_model u_arc_seq_model (.sys_clk(sys_clk), .cmd_ready(cmd_ready), .done(done),
        .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_param(cmd_param),
        .cmd_thread2(cmd_thread2));

    // free running clock
    always #10 sys_clk = ~sys_clk;

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkf(input logic [2:0] got, input logic [2:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // two register loads on back-to-back edges
    task automatic load2(input logic [7:0] i0, input logic [31:0] d0, input logic [7:0] i1,
        input logic [31:0] d1, input logic thr);
        load_en <= 1'b1;
        load_thread2 <= thr;
        load_idx <= i0;
        load_data <= d0;
        @(posedge sys_clk);
        load_idx <= i1;
        load_data <= d1;
        @(posedge sys_clk);
        load_en <= 1'b0;
    endtask

    task automatic read_reg(input logic [7:0] i, input logic thr, output logic [31:0] v);
        rd_idx <= i;
        rd_thread2 <= thr;
        repeat (2) @(posedge sys_clk);
        v = rd_data;
    endtask

    function automatic logic [2:0] exp_flags(input logic [31:0] r);
        return {r[31], !r[31] && r != 32'h0, r == 32'h0};
    endfunction

    function automatic logic [31:0] exp_val(input logic [4:0] c, input logic [31:0] a,
        input logic [31:0] b);
        int sa, d, r;
        sa = a;
        d = {16'h0000, b[15:0]};
        r = sa % d;
        case (c)
            5'h00: return 32'h0;
            5'h01: return a + b;
            5'h02: return a - b;
            5'h03: return b;
            5'h04: return b + 32'h1;
            5'h05: return b - 32'h1;
            5'h06: return b[31] ? -b : b;
            5'h08: return a;
            5'h09: return {{16{b[31]}}, b[31:16]};
            5'h0A: return {{16{b[15]}}, b[15:0]};
            5'h0B: return a & b;
            5'h0C: return a | b;
            5'h0D: return a ^ b;
            5'h0E: return 32'(sa / d);
            5'h0F, 5'h10: return a * b;
            5'h11: return {b[15:0], a[15:0]};
            5'h14: return {a[15:0], b[15:0]};
            5'h15: return {b[31:16], a[15:0]};
            5'h16: return {b[30:0], 1'b0};
            5'h17: return {b[31], b[31:1]};
            5'h18: return {1'b0, b[31:1]};
            5'h19: return 32'((r < 0) ? r + d : r);
            5'h1A: return ($signed(a) > $signed(b)) ? a : b;
            5'h1B: return ($signed(a) < $signed(b)) ? a : b;
            5'h1C: return b - a;
            5'h1D: return -b;
            5'h1E: return a + {{16{b[31]}}, b[31:16]};
            default: return a + {{16{b[15]}}, b[15:0]};
        endcase
    endfunction

    task automatic t_reset;
        chk32({29'h0, cmd_ready, done, 1'b0}, 32'h4);
        chk32(result, 32'h0);
        chkf(flags_t1 | flags_t2, 3'h0);
    endtask

    task automatic t_ops(input logic thr);
        logic [31:0] e, lat, v;
        logic [2:0] oth;
        for (int c = 0; c < 32; c++) begin
            if (c == 7 || c == 18 || c == 19) continue;
            e = exp_val(c[4:0], 32'hFFFF_FF9C, 32'h8005_0007);
            load2(8'h0A, 32'hFFFF_FF9C, 8'h0B, 32'h8005_0007, thr);
            oth = thr ? flags_t1 : flags_t2;
            u_arc_seq_model.issue(16'h00A5, c[7:0], 8'h0B, thr, 0, lat);
            chk32(lat, (c == 14 || c == 25) ? 32'h24 : 32'h3);
            chk32(result, e);
            chkf(thr ? flags_t2 : flags_t1, exp_flags(e));
            chkf(thr ? flags_t1 : flags_t2, oth);
            read_reg(REG_OPS[c] ? 8'h0B : 8'h0A, thr, v);
            chk32(v, e);
        end
        // thread one accumulator untouched by a thread two pass
        if (thr) begin
            read_reg(8'h0A, 1'b0, v);
            chk32(v, exp_val(5'h1F, 32'hFFFF_FF9C, 32'h8005_0007));
        end
    endtask

    task automatic t_pos_ind;
        logic [31:0] lat, v;
        load2(8'h14, 32'h0000_03E8, 8'h15, 32'h0000_01F4, 1'b0);
        load2(8'h0B, 32'h0000_012C, 8'h0D, 32'h1234_5678, 1'b0);
        u_arc_seq_model.issue(16'h00A5, 8'h07, 8'h0B, 1'b0, 2, lat);
        read_reg(8'h15, 1'b0, v);
        chk32(v, 32'h0000_00C8);
        chk32(result, 32'h0000_02BC);
        load2(8'h0B, 32'h0000_000D, 8'h0C, 32'h0000_000E, 1'b0);
        u_arc_seq_model.issue(16'h00A5, 8'h12, 8'h0B, 1'b0, 0, lat);
        chk32(result, 32'h1234_5678);
        u_arc_seq_model.issue(16'h00A5, 8'h13, 8'h0C, 1'b0, 0, lat);
        read_reg(8'h0E, 1'b0, v);
        chk32(v, 32'h1234_5678);
    endtask

    // foreign opcode and code above range
    task automatic t_noop;
        logic [31:0] lat, v;
        load2(8'h0A, 32'h0000_0055, 8'h0B, 32'h0000_0001, 1'b0);
        u_arc_seq_model.issue(16'h00A5, 8'h01, 8'h0B, 1'b0, 0, lat);
        u_arc_seq_model.issue(16'h0042, 8'h01, 8'h0B, 1'b0, 3, lat);
        chk32(result, 32'h0000_0056);
        u_arc_seq_model.issue(16'h00A5, 8'h20, 8'h0B, 1'b0, 0, lat);
        chk32(lat, 32'h3);
        chkf(flags_t1, 3'h2);
        read_reg(8'h0A, 1'b0, v);
        chk32(v, 32'h0000_0056);
    endtask

    task automatic complete_run;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (6000) @(posedge sys_clk);
        failures++;
        complete_run();
    end

    // reset then scenarios
    initial begin
        sys_clk = 1'b0;
        resetn = 1'b0;
        load_en = 1'b0;
        load_thread2 = 1'b0;
        load_idx = 8'h00;
        load_data = 32'h0;
        rd_idx = 8'h00;
        rd_thread2 = 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        t_reset();
        t_ops(1'b0);
        t_ops(1'b1);
        t_pos_ind();
        t_noop();
        complete_run();
    end
endmodule
`default_nettype wire
